/* src/rs485_dual_port.sv */
// Purpose: Two serial ports with RS-485 driver direction and receiver echo control
// Assumes: Host side is a byte stream per port; straps are static during traffic
// Notes:   Line pins are single ended; the transceiver sits outside
`timescale 1ns/1ps

// Notes on behaviour
// R1: Only one node drives the bus; idle nodes keep their driver off.
// R2: Rts keyed mode enables the driver exactly while rts is asserted.
// R3: Automatic mode switches the driver from transmit activity, no software action.
// R4: Echo setting leaves receiver on, so sent characters come back.
// R5: No-echo setting mutes the receiver whenever the driver is on in multidrop; full duplex never mutes it.
// R6: Full duplex keeps the driver always on; rts may reach the connector.
// R7: Multidrop gates the driver by rts or automatic; no rts at connector.
// R8: Full duplex passes rts to connector only with rts driver mode chosen.
// R9: Each port has its own driver mode and echo selection.
// R10: Serial controller has programmable baud and 16 byte transmit and receive fifos.
// R11: Automatic driver turns on before start bit, off after final stop bit.
module rs485_dual_port (
	input  wire logic                         sys_clk_i,
	input  wire logic                         rst_i,
	input  wire logic [rs485_pkg::BAUD_W-1:0] port1_baud_div_i,
	input  wire rs485_pkg::drv_mode_t         port1_driver_mode_select_i,
	input  wire rs485_pkg::echo_sel_t         port1_echo_select_i,
	input  wire logic                         port1_rts_i,
	input  wire rs485_pkg::byte_stream_t      port1_tx_i,
	output logic                              port1_tx_ready_o,
	output rs485_pkg::byte_stream_t           port1_rx_o,
	input  wire logic                         port1_rx_ready_i,
	input  wire logic                         port1_rxd_i,
	output logic                              port1_txd_o,
	output logic                              port1_drv_en_o,
	output logic                              port1_rts_line_o,
	input  wire logic [rs485_pkg::BAUD_W-1:0] port2_baud_div_i,
	input  wire rs485_pkg::drv_mode_t         port2_driver_mode_select_i,
	input  wire rs485_pkg::echo_sel_t         port2_echo_select_i,
	input  wire logic                         port2_rts_i,
	input  wire rs485_pkg::byte_stream_t      port2_tx_i,
	output logic                              port2_tx_ready_o,
	output rs485_pkg::byte_stream_t           port2_rx_o,
	input  wire logic                         port2_rx_ready_i,
	input  wire logic                         port2_rxd_i,
	output logic                              port2_txd_o,
	output logic                              port2_drv_en_o,
	output logic                              port2_rts_line_o
);
	import rs485_pkg::*;

	// Separate instances share only clock and reset, so one port's straps cannot reach the other
	line_port u_port1 ( // R9
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .baud_div_i(port1_baud_div_i),
		.drv_mode_i(port1_driver_mode_select_i), .echo_sel_i(port1_echo_select_i), .rts_i(port1_rts_i),
		.tx_i(port1_tx_i), .tx_ready_o(port1_tx_ready_o), .rx_o(port1_rx_o), .rx_ready_i(port1_rx_ready_i),
		.rxd_i(port1_rxd_i), .txd_o(port1_txd_o), .drv_en_o(port1_drv_en_o), .rts_line_o(port1_rts_line_o)
	);

	line_port u_port2 ( // R9
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .baud_div_i(port2_baud_div_i),
		.drv_mode_i(port2_driver_mode_select_i), .echo_sel_i(port2_echo_select_i), .rts_i(port2_rts_i),
		.tx_i(port2_tx_i), .tx_ready_o(port2_tx_ready_o), .rx_o(port2_rx_o), .rx_ready_i(port2_rx_ready_i),
		.rxd_i(port2_rxd_i), .txd_o(port2_txd_o), .drv_en_o(port2_drv_en_o), .rts_line_o(port2_rts_line_o)
	);
endmodule

module byte_fifo #(
	parameter int DEPTH = 2
) (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        in_valid_i,
	output logic                             in_ready_o,
	input  wire logic [rs485_pkg::DATA_W-1:0] in_data_i,
	output logic                             out_valid_o,
	input  wire logic                        out_ready_i,
	output logic [rs485_pkg::DATA_W-1:0]     out_data_o
);
	import rs485_pkg::*;
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [PW-1:0]     wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [CW-1:0]     count_q, count_d;
	logic              push, pop;

	assign in_ready_o  = (count_q != FULL_CNT);
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];

	always_comb begin
		push     = in_valid_i & in_ready_o;
		pop      = out_valid_o & out_ready_i;
		wr_ptr_d = push ? ((wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1) : wr_ptr_q;
		rd_ptr_d = pop ? ((rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1) : rd_ptr_q;
		count_d  = count_q + CW'(push) - CW'(pop);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end
	chk_fifo_full_stall: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R10
		(count_q == FULL_CNT) |-> !in_ready_o ##1 $stable(wr_ptr_q))
		else $error("fifo accepted a word while full");
	cov_fifo_full: cover property (@(posedge sys_clk_i) disable iff (rst_i) count_q == FULL_CNT);
endmodule

module line_port (
	input  wire logic                         sys_clk_i,
	input  wire logic                         rst_i,
	input  wire logic [rs485_pkg::BAUD_W-1:0] baud_div_i,
	input  wire rs485_pkg::drv_mode_t         drv_mode_i,
	input  wire rs485_pkg::echo_sel_t         echo_sel_i,
	input  wire logic                         rts_i,
	input  wire rs485_pkg::byte_stream_t      tx_i,
	output logic                              tx_ready_o,
	output rs485_pkg::byte_stream_t           rx_o,
	input  wire logic                         rx_ready_i,
	input  wire logic                         rxd_i,
	output logic                              txd_o,
	output logic                              drv_en_o,
	output logic                              rts_line_o
);
	import rs485_pkg::*;

	logic [BAUD_W-1:0] baud_cnt_q, baud_cnt_d;
	logic              tick, tx_valid, tx_pop, tx_go, auto_md, rts_md, full_dx;
	logic [DATA_W-1:0] tx_data, rxf_data;
	tx_state_t         tx_state_q, tx_state_d;
	logic [9:0]        tx_shift_q, tx_shift_d;
	logic [3:0]        tx_bits_q, tx_bits_d, tx_ovs_q, tx_ovs_d;
	logic              drv_en_q, drv_en_d, rts_line_q, rts_line_d;
	logic              rxd_meta_q, rxd_sync_q, rx_line;
	rx_state_t         rx_state_q, rx_state_d;
	logic [3:0]        rx_ovs_q, rx_ovs_d;
	logic [2:0]        rx_bits_q, rx_bits_d;
	logic [DATA_W-1:0] rx_shift_q, rx_shift_d;
	logic              rx_push_q, rx_push_d, rxf_valid, rxf_ready;

	assign full_dx = (echo_sel_i.line_mode == LINE_FULL_DUPLEX);
	assign auto_md = !full_dx && (drv_mode_i == DRV_AUTO);
	assign rts_md  = !full_dx && (drv_mode_i == DRV_RTS);
	assign tick    = (baud_cnt_q == baud_div_i);
	// Auto mode holds the first start bit until the driver is already on
	assign tx_go   = tick && tx_valid && (!auto_md || drv_en_q); // R11
	// In multidrop without echo, listen to idle while talking, so own characters never arrive
	assign rx_line = (!full_dx && echo_sel_i.rx_echo == RX_NO_ECHO && drv_en_q) ? 1'b1 : rxd_sync_q; // R5 R4

	assign txd_o      = tx_shift_q[0];
	assign drv_en_o   = drv_en_q;
	assign rts_line_o = rts_line_q;

	always_comb begin
		baud_cnt_d = tick ? BAUD_CNT_RST : baud_cnt_q + 1'b1;
		if (full_dx) begin
			drv_en_d = 1'b1; // R6
		end else if (rts_md) begin
			drv_en_d = rts_i; // R2 R7
		end else begin
			drv_en_d = tx_valid || (tx_state_q == TX_SEND); // R3 R7 R11 R1
		end
		rts_line_d = full_dx && (drv_mode_i == DRV_RTS) && rts_i; // R6 R7 R8
	end

	always_comb begin
		tx_state_d = tx_state_q;
		tx_shift_d = tx_shift_q;
		tx_bits_d  = tx_bits_q;
		tx_ovs_d   = tx_ovs_q;
		tx_pop     = 1'b0;
		unique case (tx_state_q)
			TX_IDLE: begin
				if (tx_go) begin
					tx_shift_d = {1'b1, tx_data, 1'b0};
					tx_bits_d  = 4'h0;
					tx_ovs_d   = 4'h0;
					tx_pop     = 1'b1;
					tx_state_d = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tick) begin
					tx_ovs_d = tx_ovs_q + 4'h1;
					if (tx_ovs_q == OVS_LAST) begin
						tx_shift_d = {1'b1, tx_shift_q[9:1]};
						tx_bits_d  = tx_bits_q + 4'h1;
						// Busy covers the whole stop bit before the driver may drop
						if (tx_bits_q == FRAME_LAST) begin
							tx_state_d = TX_IDLE; // R11
						end
					end
				end
			end
		endcase
	end

	always_comb begin
		rx_state_d = rx_state_q;
		rx_ovs_d   = rx_ovs_q;
		rx_bits_d  = rx_bits_q;
		rx_shift_d = rx_shift_q;
		rx_push_d  = 1'b0;
		unique case (rx_state_q)
			RX_IDLE: begin
				if (!rx_line) begin
					rx_ovs_d   = 4'h0;
					rx_state_d = RX_START;
				end
			end
			RX_START: begin
				if (tick) begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == OVS_HALF) begin
						rx_ovs_d   = 4'h0;
						rx_bits_d  = 3'h0;
						// A glitch shorter than half a bit is not a start
						rx_state_d = rx_line ? RX_IDLE : RX_DATA;
					end
				end
			end
			RX_DATA: begin
				if (tick) begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == OVS_LAST) begin
						rx_shift_d = {rx_line, rx_shift_q[DATA_W-1:1]};
						rx_bits_d  = rx_bits_q + 3'h1;
						if (rx_bits_q == DATA_LAST) begin
							rx_state_d = RX_STOP;
						end
					end
				end
			end
			RX_STOP: begin
				if (tick) begin
					rx_ovs_d = rx_ovs_q + 4'h1;
					if (rx_ovs_q == OVS_LAST) begin
						rx_push_d  = rx_line;
						rx_state_d = RX_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			baud_cnt_q <= BAUD_CNT_RST;
			drv_en_q   <= 1'b0;
			rts_line_q <= 1'b0;
			tx_state_q <= TX_IDLE;
			tx_shift_q <= TX_IDLE_LINE;
			tx_bits_q  <= 4'h0;
			tx_ovs_q   <= 4'h0;
			rxd_meta_q <= 1'b1;
			rxd_sync_q <= 1'b1;
			rx_state_q <= RX_IDLE;
			rx_ovs_q   <= 4'h0;
			rx_bits_q  <= 3'h0;
			rx_shift_q <= '0;
			rx_push_q  <= 1'b0;
		end else begin
			baud_cnt_q <= baud_cnt_d;
			drv_en_q   <= drv_en_d;
			rts_line_q <= rts_line_d;
			tx_state_q <= tx_state_d;
			tx_shift_q <= tx_shift_d;
			tx_bits_q  <= tx_bits_d;
			tx_ovs_q   <= tx_ovs_d;
			rxd_meta_q <= rxd_i;
			rxd_sync_q <= rxd_meta_q;
			rx_state_q <= rx_state_d;
			rx_ovs_q   <= rx_ovs_d;
			rx_bits_q  <= rx_bits_d;
			rx_shift_q <= rx_shift_d;
			rx_push_q  <= rx_push_d;
		end
	end

	byte_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo ( // R10
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_valid_i(tx_i.valid), .in_ready_o(tx_ready_o),
		.in_data_i(tx_i.data), .out_valid_o(tx_valid), .out_ready_i(tx_pop), .out_data_o(tx_data)
	);
	// The line cannot be stalled; a full receive path drops the new byte
	byte_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo ( // R10
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_valid_i(rx_push_q), .in_ready_o(),
		.in_data_i(rx_shift_q), .out_valid_o(rxf_valid), .out_ready_i(rxf_ready), .out_data_o(rxf_data)
	);
	byte_fifo #(.DEPTH(SKID_DEPTH)) u_rx_skid (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_valid_i(rxf_valid), .in_ready_o(rxf_ready),
		.in_data_i(rxf_data), .out_valid_o(rx_o.valid), .out_ready_i(rx_ready_i), .out_data_o(rx_o.data)
	);
	chk_rts_keys_driver: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R2
		rts_md |=> (drv_en_q == $past(rts_i)))
		else $error("driver enable does not follow rts");
	chk_auto_start_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R11
		(auto_md && tx_state_q == TX_IDLE && tx_state_d == TX_SEND) |-> drv_en_q)
		else $error("start bit sent with driver off");
	chk_auto_hold_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R3
		(auto_md && tx_state_q == TX_SEND) |=> drv_en_q)
		else $error("driver dropped mid character");
	chk_auto_release: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R1
		(auto_md && tx_state_q == TX_IDLE && !tx_valid) |=> !drv_en_q)
		else $error("driver left on with nothing to send");
	chk_full_duplex_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R6
		full_dx |=> drv_en_q)
		else $error("full duplex driver not enabled");
	chk_rts_line_out: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R8
		full_dx |=> (rts_line_q == ($past(rts_i) && $past(drv_mode_i) == DRV_RTS)))
		else $error("rts line output wrong in full duplex");
	chk_multidrop_rts_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R7
		!full_dx |=> !rts_line_q)
		else $error("rts reached connector in multidrop");
	chk_no_echo_mute: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R5
		(!full_dx && echo_sel_i.rx_echo == RX_NO_ECHO && drv_en_q && rx_state_q == RX_IDLE) |=>
		(rx_state_q == RX_IDLE))
		else $error("receiver active while talking without echo");
	chk_echo_listens: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
		(echo_sel_i.rx_echo == RX_ECHO) |-> (rx_line == rxd_sync_q))
		else $error("echo mode receiver not on line");
	cov_auto_frame: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		auto_md && tx_state_q == TX_SEND ##1 tx_state_q == TX_IDLE ##1 !drv_en_q);
	cov_rx_byte: cover property (@(posedge sys_clk_i) disable iff (rst_i) rx_push_q);
	cov_rts_send: cover property (@(posedge sys_clk_i) disable iff (rst_i) rts_md && drv_en_q && tx_pop);
endmodule

/* src/rs485_pkg.sv */
// Purpose: Shared types and constants for the dual RS-485 line controller
// Assumes: 8 data bits, no parity, one stop bit; 16x oversampled bit timing
// Notes:   Line setting codes follow the strap positions of each port
package rs485_pkg;
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int SKID_DEPTH = 2;
	localparam int BAUD_W     = 16;

	localparam logic [3:0] OVS_LAST   = 4'hF;
	localparam logic [3:0] OVS_HALF   = 4'h7;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	localparam logic [2:0] DATA_LAST  = 3'h7;
	localparam logic [9:0] TX_IDLE_LINE = 10'h3FF;
	localparam logic [BAUD_W-1:0] BAUD_CNT_RST = 16'h0000;

	typedef enum logic {
		DRV_RTS  = 1'b0,
		DRV_AUTO = 1'b1
	} drv_mode_t;

	typedef enum logic {
		RX_ECHO    = 1'b0,
		RX_NO_ECHO = 1'b1
	} rx_echo_t;

	typedef enum logic {
		LINE_FULL_DUPLEX = 1'b0,
		LINE_MULTIDROP   = 1'b1
	} line_mode_t;

	typedef struct packed {
		rx_echo_t   rx_echo;
		line_mode_t line_mode;
	} echo_sel_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} byte_stream_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;
endpackage

/* test/bus_node.sv */
// Purpose: Other node on the shared two-wire line of port 1
// Assumes: 8N1 framing, LSB first, fixed clocks per bit
// Notes:   Released line reads as mark through the bias pull-up
`timescale 1ns/1ps

module bus_node #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic sys_clk_i,
	input  wire logic dut_drv_en_i,
	input  wire logic dut_txd_i,
	output logic      line_o,
	output logic      collide_o
);
	logic node_en;
	logic node_bit;

	// Bias pull-up, so an undriven line never shows stale data
	assign line_o = dut_drv_en_i ? dut_txd_i : (node_en ? node_bit : 1'b1);

	initial begin
		node_en = 1'b0;
		node_bit = 1'b1;
		collide_o = 1'b0;
	end

	always @(posedge sys_clk_i) begin
		if (node_en && dut_drv_en_i) begin
			collide_o <= 1'b1;
		end
	end

	task automatic send_byte(input logic [7:0] d);
		logic [9:0] frame;
		frame = {1'b1, d, 1'b0};
		// Waits for the line to be free before keying the driver
		while (dut_drv_en_i) @(negedge sys_clk_i);
		node_en = 1'b1;
		for (int b = 0; b < 10; b++) begin
			node_bit = frame[b];
			repeat (BIT_CLKS) @(negedge sys_clk_i);
		end
		node_en = 1'b0;
	endtask
endmodule

/* test/tb_rs485_dual_port.sv */
// Purpose: Self-checking bench for the dual line controller
// Assumes: Divider 0, so one bit is 16 clocks; the rts case runs port 1 at divider 1
// Notes:   Port 1 on a two-wire line, port 2 looped back four-wire
`timescale 1ns/1ps

module tb_rs485_dual_port;
	import rs485_pkg::*;

	typedef struct packed {
		drv_mode_t dm;
		echo_sel_t es;
		logic      rts;
		logic      den;
		logic      rl;
	} row_t;

	localparam row_t ROWS [6] = '{
		'{DRV_RTS,  '{RX_ECHO, LINE_FULL_DUPLEX}, 1'b0, 1'b1, 1'b0},
		'{DRV_RTS,  '{RX_NO_ECHO, LINE_FULL_DUPLEX}, 1'b1, 1'b1, 1'b1},
		'{DRV_AUTO, '{RX_ECHO, LINE_FULL_DUPLEX}, 1'b1, 1'b1, 1'b0},
		'{DRV_RTS,  '{RX_ECHO, LINE_MULTIDROP}, 1'b1, 1'b1, 1'b0},
		'{DRV_RTS,  '{RX_NO_ECHO, LINE_MULTIDROP}, 1'b0, 1'b0, 1'b0},
		'{DRV_AUTO, '{RX_ECHO, LINE_MULTIDROP}, 1'b1, 1'b0, 1'b0}
	};

	logic         sys_clk_i;
	logic         rst_i;
	logic [15:0]  bd1;
	drv_mode_t    dm1;
	drv_mode_t    dm2;
	echo_sel_t    es1;
	echo_sel_t    es2;
	logic         rts1;
	logic         rts2;
	logic         rr1;
	logic         rr2;
	byte_stream_t tx1;
	byte_stream_t tx2;
	byte_stream_t rx1;
	byte_stream_t rx2;
	logic         trdy1;
	logic         trdy2;
	logic         txd1;
	logic         txd2;
	logic         den1;
	logic         den2;
	logic         rl1;
	logic         rl2;
	logic         bus_line;
	logic         collide;
	logic [8:0]   got;
	logic [7:0]   gd;
	logic         ok;
	int           n_fail;
	int           cmp_count;
	int           refusals;

	rs485_dual_port u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.port1_baud_div_i(bd1), .port1_driver_mode_select_i(dm1), .port1_echo_select_i(es1),
		.port1_rts_i(rts1), .port1_tx_i(tx1), .port1_tx_ready_o(trdy1), .port1_rx_o(rx1),
		.port1_rx_ready_i(rr1), .port1_rxd_i(bus_line), .port1_txd_o(txd1), .port1_drv_en_o(den1),
		.port1_rts_line_o(rl1),
		.port2_baud_div_i(16'h0000), .port2_driver_mode_select_i(dm2), .port2_echo_select_i(es2),
		.port2_rts_i(rts2), .port2_tx_i(tx2), .port2_tx_ready_o(trdy2), .port2_rx_o(rx2),
		.port2_rx_ready_i(rr2), .port2_rxd_i(txd2), .port2_txd_o(txd2), .port2_drv_en_o(den2),
		.port2_rts_line_o(rl2)
	);

	bus_node #(.BIT_CLKS(16)) u_node (
		.sys_clk_i(sys_clk_i), .dut_drv_en_i(den1), .dut_txd_i(txd1), .line_o(bus_line), .collide_o(collide)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	task automatic check(input logic [8:0] g, input logic [8:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		$display("Counts: %0d mismatches in %0d comparisons", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Holds valid and data until ready is seen; caller drops valid
	task automatic push(input bit p2, input logic [7:0] d);
		int w;
		w = 0;
		if (p2) tx2 = '{1'b1, d};
		else tx1 = '{1'b1, d};
		while ((p2 ? trdy2 : trdy1) !== 1'b1 && w < 400) begin
			@(negedge sys_clk_i);
			w++;
			refusals++;
		end
		if (w >= 400) n_fail++;
		@(negedge sys_clk_i);
	endtask

	// One idle cycle before each take, which also stalls the buffer
	task automatic pull(input bit p2, output logic [8:0] g);
		int w;
		w = 0;
		@(negedge sys_clk_i);
		while ((p2 ? rx2.valid : rx1.valid) !== 1'b1 && w < 300) begin
			@(negedge sys_clk_i);
			w++;
		end
		if (w >= 300) n_fail++;
		g = p2 ? rx2 : rx1;
		if (p2) rr2 = 1'b1;
		else rr1 = 1'b1;
		@(negedge sys_clk_i);
		rr1 = 1'b0;
		rr2 = 1'b0;
	endtask

	// Samples the port 1 frame at mid-bit; driver must stay on throughout
	task automatic grab(input int bc, output logic [7:0] d, output logic f);
		int w;
		w = 0;
		while (txd1 !== 1'b0 && w < 200) begin
			@(negedge sys_clk_i);
			w++;
		end
		if (w >= 200) n_fail++;
		repeat (bc / 2) @(negedge sys_clk_i);
		f = (txd1 === 1'b0) && (den1 === 1'b1);
		for (int b = 0; b < 8; b++) begin
			repeat (bc) @(negedge sys_clk_i);
			d[b] = txd1;
			f = f && (den1 === 1'b1);
		end
		repeat (bc) @(negedge sys_clk_i);
		f = f && (txd1 === 1'b1) && (den1 === 1'b1);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		cmp_count = 0;
		refusals = 0;
		rst_i = 1'b1;
		bd1 = 16'h0000;
		dm1 = DRV_RTS;
		dm2 = DRV_RTS;
		es1 = '{RX_ECHO, LINE_MULTIDROP};
		es2 = '{RX_ECHO, LINE_FULL_DUPLEX};
		rts1 = 1'b0;
		rts2 = 1'b1;
		rr1 = 1'b0;
		rr2 = 1'b0;
		tx1 = '{1'b0, 8'h00};
		tx2 = '{1'b0, 8'h00};
		repeat (4) @(negedge sys_clk_i);
		check({4'h0, txd1, den1, rl1, trdy1, rx1.valid}, 9'h012);
		rst_i = 1'b0;
		// Static strap cases; port 2 must not move
		foreach (ROWS[i]) begin
			dm1 = ROWS[i].dm;
			es1 = ROWS[i].es;
			rts1 = ROWS[i].rts;
			repeat (3) @(negedge sys_clk_i);
			check({7'h00, den1, rl1}, {7'h00, ROWS[i].den, ROWS[i].rl});
			check({7'h00, den2, rl2}, 9'h003);
		end
		// Automatic keying with echo
		check({8'h00, den1}, 9'h000);
		push(1'b0, 8'hA5);
		tx1.valid = 1'b0;
		grab(16, gd, ok);
		check({ok, gd}, 9'h1A5);
		repeat (12) @(negedge sys_clk_i);
		check({8'h00, den1}, 9'h000);
		pull(1'b0, got);
		check(got, 9'h1A5);
		// Echo suppressed: own byte must not come back
		es1 = '{RX_NO_ECHO, LINE_MULTIDROP};
		push(1'b0, 8'h3C);
		tx1.valid = 1'b0;
		grab(16, gd, ok);
		check({ok, gd}, 9'h13C);
		repeat (40) @(negedge sys_clk_i);
		check({8'h00, rx1.valid}, 9'h000);
		// Receiver live again once the driver is off
		u_node.send_byte(8'h5A);
		pull(1'b0, got);
		check(got, 9'h15A);
		check({8'h00, collide}, 9'h000);
		// Rts keyed send at half the bit rate; transmitter does not wait for the driver
		dm1 = DRV_RTS;
		bd1 = 16'h0001;
		rts1 = 1'b1;
		push(1'b0, 8'hC3);
		tx1.valid = 1'b0;
		grab(32, gd, ok);
		check({ok, gd}, 9'h1C3);
		repeat (20) @(negedge sys_clk_i);
		rts1 = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		check({8'h00, den1}, 9'h000);
		// Port 2: overrun both buffers, host stalled
		for (int i = 0; i < 20; i++) begin
			push(1'b1, 8'h40 + 8'(i));
		end
		tx2.valid = 1'b0;
		check({8'h00, refusals > 0}, 9'h001);
		repeat (3000) @(negedge sys_clk_i);
		for (int i = 0; i < 18; i++) begin
			pull(1'b1, got);
			check(got, {1'b1, 8'h40 + 8'(i)});
		end
		repeat (4) @(negedge sys_clk_i);
		check({8'h00, rx2.valid}, 9'h000);
		finish_test();
	end
endmodule
